// File: hw/mbpm_pmon.sv
// Bridge monitoring unit: counters, filter registers, config access
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Four 48-bit counters, each with its own control register, can each count any selectable event.
// - Packets from the mesh are matched on class, opcode and address; commands toward memory on opcode and address.
// - The number of filter hits is a packet-match event that any counter may select.
// - Incoming and outgoing traffic are filtered at the same time, with separate opcode fields and one shared address match and mask.
// - Bits 27:22 of the opcode filter hold the outgoing opcode mask, resetting to zero.
// - Bits 21:16 hold the outgoing opcode match value, resetting to zero.
// - Bits 15:12 hold the incoming message class mask, resetting to zero.
// - Bits 11:8 hold the incoming class match: request 0, response 2, bypass A, standard B, writeback C.
// - Bits 7:4 hold the incoming opcode mask, resetting to zero.
// - Bits 3:0 hold the incoming opcode match value, resetting to zero.
// - The low address mask and match registers hold address bits 31:0, resetting to zero.
// - The high address registers hold upper address bits in 14:0, bits 31:15 stay zero.
module mbpm_pmon (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration space access
  input wire logic [mbpm_pkg::CFG_AW-1:0] cfgAddr,
  input wire logic cfgWr,
  input wire logic cfgRd,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWdata,
  output logic [31:0] cfgRdata,
  output logic cfgRdValid,
  // Packets from the mesh toward memory
  input wire logic inValid,
  input wire logic [3:0] inClass,
  input wire logic [3:0] inOpcode,
  input wire logic [mbpm_pkg::ADDR_W-1:0] inAddr,
  // Commands toward the memory controller
  input wire logic outValid,
  input wire logic [5:0] outOpcode,
  input wire logic [mbpm_pkg::ADDR_W-1:0] outAddr,
  // Generic unit events
  input wire logic [mbpm_pkg::NUM_GEN_EV-1:0] genEvent
);
  import mbpm_pkg::*;

  logic [31:0] opcFilt_r, opcFilt_nxt;
  logic [31:0] matchLo_r, matchLo_nxt;
  logic [31:0] matchHi_r, matchHi_nxt;
  logic [31:0] maskLo_r, maskLo_nxt;
  logic [31:0] maskHi_r, maskHi_nxt;
  logic [31:0] ctl_r [NUM_CTR];
  logic [31:0] ctl_nxt [NUM_CTR];
  logic [CTR_W-1:0] ctr_r [NUM_CTR];
  logic [CTR_W-1:0] ctr_nxt [NUM_CTR];
  logic [31:0] rdata_r, rdata_nxt;
  logic rdValid_r, rdValid_nxt;
  logic [NUM_CTR-1:0] ctrClr;

  mbpm_match_if mif();

  assign mif.opcFilt = opcFilt_r;
  assign mif.addrMatch = {matchHi_r[ADDR_HI_W-1:0], matchLo_r};
  assign mif.addrMask = {maskHi_r[ADDR_HI_W-1:0], maskLo_r};
  assign mif.inValid = inValid;
  assign mif.inClass = inClass;
  assign mif.inOpcode = inOpcode;
  assign mif.inAddr = inAddr;
  assign mif.outValid = outValid;
  assign mif.outOpcode = outOpcode;
  assign mif.outAddr = outAddr;

  mbpm_match u_match (
    .clk(clk),
    .rst(rst),
    .m(mif.filt)
  );

  // Per-cycle increment chosen by a control register
  function automatic logic [1:0] ev_inc(input logic [31:0] ctl, input logic [1:0] hits,
                                        input logic [NUM_GEN_EV-1:0] ev);
    logic [CTL_SEL_W-1:0] sel;
    sel = ctl[CTL_SEL_W-1:0];
    if (!ctl[CTL_EN_BIT]) begin
      return 2'h0;
    end else if (sel == EV_PKT_HIT) begin
      return hits;
    end else if (sel != EV_NOTHING && sel < CTL_SEL_W'(NUM_GEN_EV)) begin
      return {1'b0, ev[sel[3:0]]};
    end
    return 2'h0;
  endfunction

  // Register writes
  always_comb begin
    opcFilt_nxt = opcFilt_r;
    matchLo_nxt = matchLo_r;
    matchHi_nxt = matchHi_r;
    maskLo_nxt = maskLo_r;
    maskHi_nxt = maskHi_r;
    ctrClr = '0;
    for (int i = 0; i < NUM_CTR; i++) begin
      ctl_nxt[i] = ctl_r[i];
    end
    if (cfgWr) begin
      if (cfgAddr == OFF_OPC_FILT) begin
        opcFilt_nxt = apply_be(opcFilt_r, cfgWdata, cfgByteEn) & OPC_FILT_WMASK;
      end else if (cfgAddr == OFF_ADDR_MATCH_LO) begin
        matchLo_nxt = apply_be(matchLo_r, cfgWdata, cfgByteEn);
      end else if (cfgAddr == OFF_ADDR_MATCH_HI) begin
        matchHi_nxt = apply_be(matchHi_r, cfgWdata, cfgByteEn) & ADDR_HI_WMASK;
      end else if (cfgAddr == OFF_ADDR_MASK_LO) begin
        maskLo_nxt = apply_be(maskLo_r, cfgWdata, cfgByteEn);
      end else if (cfgAddr == OFF_ADDR_MASK_HI) begin
        maskHi_nxt = apply_be(maskHi_r, cfgWdata, cfgByteEn) & ADDR_HI_WMASK;
      end else begin
        for (int i = 0; i < NUM_CTR; i++) begin
          if (cfgAddr == ctl_off(i)) begin
            ctl_nxt[i] = apply_be(ctl_r[i], cfgWdata, cfgByteEn) & CTL_WMASK;
            ctrClr[i] = cfgByteEn[2] && cfgWdata[CTL_CLR_BIT];
          end
        end
      end
    end
  end

  // Counters; a clear request beats a same-cycle count
  always_comb begin
    for (int i = 0; i < NUM_CTR; i++) begin
      if (ctrClr[i]) begin
        ctr_nxt[i] = '0;
      end else begin
        ctr_nxt[i] = ctr_r[i] + {46'h0, ev_inc(ctl_r[i], mif.hitCnt, genEvent)};
      end
    end
  end

  // Read data, one cycle after the request
  always_comb begin
    rdValid_nxt = cfgRd;
    rdata_nxt = 32'h0000_0000;
    if (cfgRd) begin
      if (cfgAddr == OFF_OPC_FILT) begin
        rdata_nxt = opcFilt_r;
      end else if (cfgAddr == OFF_ADDR_MATCH_LO) begin
        rdata_nxt = matchLo_r;
      end else if (cfgAddr == OFF_ADDR_MATCH_HI) begin
        rdata_nxt = matchHi_r;
      end else if (cfgAddr == OFF_ADDR_MASK_LO) begin
        rdata_nxt = maskLo_r;
      end else if (cfgAddr == OFF_ADDR_MASK_HI) begin
        rdata_nxt = maskHi_r;
      end else begin
        for (int i = 0; i < NUM_CTR; i++) begin
          if (cfgAddr == ctl_off(i)) begin
            rdata_nxt = ctl_r[i];
          end else if (cfgAddr == ctr_off(i)) begin
            rdata_nxt = ctr_r[i][31:0];
          end else if (cfgAddr == ctr_off(i) + OFF_CTR_HI) begin
            rdata_nxt = {16'h0000, ctr_r[i][CTR_W-1:32]};
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opcFilt_r <= FILT_RST;
      matchLo_r <= FILT_RST;
      matchHi_r <= FILT_RST;
      maskLo_r <= FILT_RST;
      maskHi_r <= FILT_RST;
      rdata_r <= 32'h0000_0000;
      rdValid_r <= 1'b0;
      for (int i = 0; i < NUM_CTR; i++) begin
        ctl_r[i] <= CTL_RST;
        ctr_r[i] <= '0;
      end
    end else begin
      opcFilt_r <= opcFilt_nxt;
      matchLo_r <= matchLo_nxt;
      matchHi_r <= matchHi_nxt;
      maskLo_r <= maskLo_nxt;
      maskHi_r <= maskHi_nxt;
      rdata_r <= rdata_nxt;
      rdValid_r <= rdValid_nxt;
      for (int i = 0; i < NUM_CTR; i++) begin
        ctl_r[i] <= ctl_nxt[i];
        ctr_r[i] <= ctr_nxt[i];
      end
    end
  end

  assign cfgRdata = rdata_r;
  assign cfgRdValid = rdValid_r;

  // Checks
  logic ctl3Wr;
  assign ctl3Wr = cfgWr && cfgAddr == ctl_off(3);

  property p_gen_count;
    @(posedge clk) disable iff (rst)
      (ctl_r[3][CTL_EN_BIT] && ctl_r[3][7:0] == 8'h01 && genEvent[1] && !ctl3Wr)
      |=> ctr_r[3] == $past(ctr_r[3]) + 48'h1;
  endproperty
  a_gen_count: assert property (p_gen_count) else $error("counter 3 missed a generic event");

  property p_hit_count;
    @(posedge clk) disable iff (rst)
      (ctl_r[1][CTL_EN_BIT] && ctl_r[1][7:0] == EV_PKT_HIT && !(cfgWr && cfgAddr == ctl_off(1)))
      |=> ctr_r[1] == $past(ctr_r[1]) + {46'h0, $past(mif.hitCnt)};
  endproperty
  a_hit_count: assert property (p_hit_count) else $error("counter 1 did not add the hit count");

  property p_open_filter;
    @(posedge clk) disable iff (rst)
      (opcFilt_r == 32'h0 && mif.addrMask == '0 && inValid && !cfgWr) ##1 (opcFilt_r == 32'h0)
      |-> mif.hitCnt != 2'h0;
  endproperty
  a_open_filter: assert property (p_open_filter) else $error("unmasked packet did not hit");

  property p_both_dirs;
    @(posedge clk) disable iff (rst)
      (opcFilt_r == 32'h0 && mif.addrMask == '0 && inValid && outValid && !cfgWr)
      |=> mif.hitCnt == 2'h2;
  endproperty
  a_both_dirs: assert property (p_both_dirs) else $error("two-direction hit not counted twice");

  property p_class_miss;
    @(posedge clk) disable iff (rst)
      (inValid && !outValid && opcFilt_r[15:12] == 4'hF && inClass != opcFilt_r[11:8])
      |=> mif.hitCnt == 2'h0;
  endproperty
  a_class_miss: assert property (p_class_miss) else $error("class mismatch counted as hit");

  property p_outopc_miss;
    @(posedge clk) disable iff (rst)
      (outValid && !inValid && opcFilt_r[27:22] == 6'h3F && outOpcode != opcFilt_r[21:16])
      |=> mif.hitCnt == 2'h0;
  endproperty
  a_outopc_miss: assert property (p_outopc_miss) else $error("outgoing opcode mismatch counted");

  property p_filt_write;
    @(posedge clk) disable iff (rst)
      (cfgWr && cfgAddr == OFF_OPC_FILT && cfgByteEn == 4'hF)
      |=> opcFilt_r == ($past(cfgWdata) & 32'h0FFF_FFFF);
  endproperty
  a_filt_write: assert property (p_filt_write) else $error("opcode filter write lost");

  property p_filt_rsv_read;
    @(posedge clk) disable iff (rst)
      (cfgRd && cfgAddr == OFF_OPC_FILT) |=> cfgRdValid && cfgRdata[31:28] == 4'h0;
  endproperty
  a_filt_rsv_read: assert property (p_filt_rsv_read) else $error("filter reserved bits not zero");

  property p_hi_read;
    @(posedge clk) disable iff (rst)
      (cfgRd && cfgAddr == OFF_ADDR_MASK_HI) |=> cfgRdValid && cfgRdata == $past(maskHi_r)
      && cfgRdata[31:15] == 17'h0;
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("high mask read wrong");

  property p_lo_write;
    @(posedge clk) disable iff (rst)
      (cfgWr && cfgAddr == OFF_ADDR_MATCH_LO && cfgByteEn == 4'hF) |=> matchLo_r == $past(cfgWdata);
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("low match write lost");

  c_hit_counted: cover property (@(posedge clk) disable iff (rst) mif.hitCnt == 2'h2);
  c_ctr_clear: cover property (@(posedge clk) disable iff (rst) ctrClr[0] && ctr_r[0] != '0);
  c_read_back: cover property (@(posedge clk) disable iff (rst) cfgRdValid && cfgRdata != 32'h0);
endmodule
`default_nettype wire

// File: hw/mbpm_pkg.sv
// Constants, types and helpers for the bridge monitoring block
package mbpm_pkg;
  localparam int CFG_AW = 12;
  localparam int ADDR_W = 47;
  localparam int CTR_W = 48;
  localparam int NUM_CTR = 4;
  localparam int NUM_GEN_EV = 16;

  // Filter register offsets
  localparam logic [CFG_AW-1:0] OFF_ADDR_MATCH_LO = 12'h490;
  localparam logic [CFG_AW-1:0] OFF_ADDR_MATCH_HI = 12'h494;
  localparam logic [CFG_AW-1:0] OFF_ADDR_MASK_LO = 12'h498;
  localparam logic [CFG_AW-1:0] OFF_ADDR_MASK_HI = 12'h49C;
  localparam logic [CFG_AW-1:0] OFF_OPC_FILT = 12'h4A0;
  // Counter words and control registers
  localparam logic [CFG_AW-1:0] OFF_CTR_BASE = 12'h400;
  localparam logic [CFG_AW-1:0] OFF_CTR_STRIDE = 12'h008;
  localparam logic [CFG_AW-1:0] OFF_CTR_HI = 12'h004;
  localparam logic [CFG_AW-1:0] OFF_CTL_BASE = 12'h420;
  localparam logic [CFG_AW-1:0] OFF_CTL_STRIDE = 12'h004;

  // Opcode and class filter fields
  localparam int OUT_OPC_MASK_LSB = 22;
  localparam int OUT_OPC_LSB = 16;
  localparam int IN_CLS_MASK_LSB = 12;
  localparam int IN_CLS_LSB = 8;
  localparam int IN_OPC_MASK_LSB = 4;
  localparam int IN_OPC_LSB = 0;
  localparam int OUT_OPC_W = 6;
  localparam int IN_FLD_W = 4;
  localparam int ADDR_HI_W = 15;

  // Writable bits and reset values
  localparam logic [31:0] OPC_FILT_WMASK = 32'h0FFF_FFFF;
  localparam logic [31:0] ADDR_HI_WMASK = 32'h0000_7FFF;
  localparam logic [31:0] CTL_WMASK = 32'h0040_00FF;
  localparam logic [31:0] FILT_RST = 32'h0000_0000;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;

  // Counter control fields
  localparam int CTL_SEL_W = 8;
  localparam int CTL_CLR_BIT = 17;
  localparam int CTL_EN_BIT = 22;
  localparam logic [CTL_SEL_W-1:0] EV_NOTHING = 8'h00;
  localparam logic [CTL_SEL_W-1:0] EV_PKT_HIT = 8'h40;

  typedef enum logic [3:0] {
    CLS_REQUEST = 4'h0,
    CLS_RESPONSE = 4'h2,
    CLS_NC_BYPASS = 4'hA,
    CLS_NC_STANDARD = 4'hB,
    CLS_WRITEBACK = 4'hC
  } mbpm_class_t;

  // Selected bits equal, unselected bits ignored
  function automatic logic masked_eq(input logic [ADDR_W-1:0] val, input logic [ADDR_W-1:0] match,
                                     input logic [ADDR_W-1:0] mask);
    return ((val ^ match) & mask) == '0;
  endfunction

  function automatic logic [31:0] apply_be(input logic [31:0] old, input logic [31:0] wdata,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [CFG_AW-1:0] ctr_off(input int idx);
    return OFF_CTR_BASE + CFG_AW'(idx) * OFF_CTR_STRIDE;
  endfunction

  function automatic logic [CFG_AW-1:0] ctl_off(input int idx);
    return OFF_CTL_BASE + CFG_AW'(idx) * OFF_CTL_STRIDE;
  endfunction
endpackage

// File: hw/mbpm_match_if.sv
// Filter settings and packet fields between control and matcher
`timescale 1ns/1ns
`default_nettype none
interface mbpm_match_if;
  import mbpm_pkg::*;
  logic [31:0] opcFilt;
  logic [ADDR_W-1:0] addrMatch;
  logic [ADDR_W-1:0] addrMask;
  logic inValid;
  logic [3:0] inClass;
  logic [3:0] inOpcode;
  logic [ADDR_W-1:0] inAddr;
  logic outValid;
  logic [5:0] outOpcode;
  logic [ADDR_W-1:0] outAddr;
  logic [1:0] hitCnt;

  modport ctrl (
    output opcFilt, addrMatch, addrMask, inValid, inClass, inOpcode, inAddr,
    output outValid, outOpcode, outAddr,
    input hitCnt
  );
  modport filt (
    input opcFilt, addrMatch, addrMask, inValid, inClass, inOpcode, inAddr,
    input outValid, outOpcode, outAddr,
    output hitCnt
  );
endinterface
`default_nettype wire

// File: hw/mbpm_match.sv
// Packet matcher for both traffic directions
`timescale 1ns/1ns
`default_nettype none
module mbpm_match (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filter settings and packets
  mbpm_match_if.filt m
);
  import mbpm_pkg::*;

  logic inHit;
  logic outHit;
  logic [1:0] hitCnt_r;
  logic [1:0] hitCnt_nxt;

  always_comb begin
    // Incoming: class, opcode and address all selected fields equal
    inHit = m.inValid
      && masked_eq(ADDR_W'(m.inClass), ADDR_W'(m.opcFilt[IN_CLS_LSB +: IN_FLD_W]),
                   ADDR_W'(m.opcFilt[IN_CLS_MASK_LSB +: IN_FLD_W]))
      && masked_eq(ADDR_W'(m.inOpcode), ADDR_W'(m.opcFilt[IN_OPC_LSB +: IN_FLD_W]),
                   ADDR_W'(m.opcFilt[IN_OPC_MASK_LSB +: IN_FLD_W]))
      && masked_eq(m.inAddr, m.addrMatch, m.addrMask);
    // Outgoing toward the memory controller
    outHit = m.outValid
      && masked_eq(ADDR_W'(m.outOpcode), ADDR_W'(m.opcFilt[OUT_OPC_LSB +: OUT_OPC_W]),
                   ADDR_W'(m.opcFilt[OUT_OPC_MASK_LSB +: OUT_OPC_W]))
      && masked_eq(m.outAddr, m.addrMatch, m.addrMask);
    // Both directions filtered at once, one count per packet
    hitCnt_nxt = {1'b0, inHit} + {1'b0, outHit};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hitCnt_r <= 2'h0;
    end else begin
      hitCnt_r <= hitCnt_nxt;
    end
  end

  assign m.hitCnt = hitCnt_r;
endmodule
`default_nettype wire

// File: tb/mbpm_pkt_src.sv
// Packet source standing in for the mesh agents and the memory controller
`timescale 1ns/1ns
`default_nettype none
module mbpm_pkt_src (
  // Clock
  input wire logic clk,
  // Packets from the mesh toward memory
  output logic inValid,
  output logic [3:0] inClass,
  output logic [3:0] inOpcode,
  output logic [mbpm_pkg::ADDR_W-1:0] inAddr,
  // Commands toward the memory controller
  output logic outValid,
  output logic [5:0] outOpcode,
  output logic [mbpm_pkg::ADDR_W-1:0] outAddr
);
  import mbpm_pkg::*;

  initial begin
    inValid = 1'b0;
    inClass = 4'h5;
    inOpcode = 4'hA;
    inAddr = '0;
    outValid = 1'b0;
    outOpcode = 6'h15;
    outAddr = '1;
  end

  // One cycle per packet; idle fields inverted so stale values never look valid
  task automatic send(input logic doIn, input logic [3:0] cls, input logic [3:0] opc,
                      input logic [ADDR_W-1:0] ia, input logic doOut, input logic [5:0] oopc,
                      input logic [ADDR_W-1:0] oa);
    @(posedge clk);
    #1;
    inValid = doIn;
    inClass = cls;
    inOpcode = opc;
    inAddr = ia;
    outValid = doOut;
    outOpcode = oopc;
    outAddr = oa;
    @(posedge clk);
    #1;
    inValid = 1'b0;
    outValid = 1'b0;
    inClass = ~inClass;
    inOpcode = ~inOpcode;
    inAddr = ~inAddr;
    outOpcode = ~outOpcode;
    outAddr = ~outAddr;
  endtask
endmodule
`default_nettype wire

// File: tb/mbpm_pmon_bench.sv
// Self-checking bench for the bridge monitoring unit
`timescale 1ns/1ns
`default_nettype none
module mbpm_pmon_bench;
  import mbpm_pkg::*;
  logic clk, rst, cfgWr, cfgRd, cfgRdValid, inValid, outValid;
  logic [CFG_AW-1:0] cfgAddr;
  logic [3:0] cfgByteEn, inClass, inOpcode;
  logic [31:0] cfgWdata, cfgRdata, fOpc;
  logic [5:0] outOpcode;
  logic [ADDR_W-1:0] inAddr, outAddr, aMask, aMatch;
  logic [NUM_GEN_EV-1:0] genEvent;
  logic [47:0] expCnt [4];
  int nErrors = 0;
  int testsRun = 0;
  localparam logic [CFG_AW-1:0] FOFF [5] = '{12'h490, 12'h494, 12'h498, 12'h49C, 12'h4A0};
  localparam logic [31:0] FONES [5] = '{32'hFFFF_FFFF, 32'h0000_7FFF, 32'hFFFF_FFFF, 32'h0000_7FFF, 32'h0FFF_FFFF};
  localparam logic [3:0] CODES [5] = '{4'h0, 4'h2, 4'hA, 4'hB, 4'hC};

  mbpm_pmon dut (.clk(clk), .rst(rst), .cfgAddr(cfgAddr), .cfgWr(cfgWr), .cfgRd(cfgRd),
    .cfgByteEn(cfgByteEn), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgRdValid(cfgRdValid),
    .inValid(inValid), .inClass(inClass), .inOpcode(inOpcode), .inAddr(inAddr), .outValid(outValid),
    .outOpcode(outOpcode), .outAddr(outAddr), .genEvent(genEvent));
  mbpm_pkt_src src (.clk(clk), .inValid(inValid), .inClass(inClass), .inOpcode(inOpcode),
    .inAddr(inAddr), .outValid(outValid), .outOpcode(outOpcode), .outAddr(outAddr));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out;
    if (nErrors == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nErrors++;
      $display("[ERR] %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cfg_wr(input logic [CFG_AW-1:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    #1;
    cfgAddr = a;
    cfgWdata = d;
    cfgByteEn = be;
    cfgWr = 1'b1;
    @(posedge clk);
    #1;
    cfgWr = 1'b0;
  endtask

  // Read data only counts when the valid pulse stands
  task automatic cfg_rd(input logic [CFG_AW-1:0] a, output logic [31:0] d);
    @(posedge clk);
    #1;
    cfgAddr = a;
    cfgRd = 1'b1;
    @(posedge clk);
    #1;
    cfgRd = 1'b0;
    d = (cfgRdValid === 1'b1) ? cfgRdata : 32'hX;
  endtask

  task automatic rd_chk(input logic [CFG_AW-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    cfg_rd(a, d);
    chk({16'h0000, d}, {16'h0000, exp});
  endtask

  task automatic ctr_chk(input int i);
    logic [31:0] lo, hi;
    repeat (3) @(posedge clk);
    cfg_rd(12'h400 + 12'(8 * i), lo);
    cfg_rd(12'h404 + 12'(8 * i), hi);
    chk({hi[15:0], lo}, expCnt[i]);
  endtask

  // Bench copy of the filters, kept in step with every filter write made through this task
  task automatic set_filt(input logic [31:0] opc, input logic [ADDR_W-1:0] mt, input logic [ADDR_W-1:0] mk);
    fOpc = opc;
    aMatch = mt;
    aMask = mk;
    cfg_wr(12'h4A0, opc, 4'hF);
    cfg_wr(12'h490, mt[31:0], 4'hF);
    cfg_wr(12'h494, {17'h00000, mt[46:32]}, 4'hF);
    cfg_wr(12'h498, mk[31:0], 4'hF);
    cfg_wr(12'h49C, {17'h00000, mk[46:32]}, 4'hF);
  endtask

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return ((a ^ aMatch) & aMask) == '0;
  endfunction

  task automatic pkt(input logic di, input logic [3:0] c, input logic [3:0] o, input logic [ADDR_W-1:0] ia,
                     input logic dout, input logic [5:0] oo, input logic [ADDR_W-1:0] oa);
    logic hi, ho;
    hi = di && (((c ^ fOpc[11:8]) & fOpc[15:12]) == 4'h0) && (((o ^ fOpc[3:0]) & fOpc[7:4]) == 4'h0) && addr_ok(ia);
    ho = dout && (((oo ^ fOpc[21:16]) & fOpc[27:22]) == 6'h00) && addr_ok(oa);
    src.send(di, c, o, ia, dout, oo, oa);
    for (int i = 0; i < 3; i++) begin
      expCnt[i] = expCnt[i] + 48'(hi) + 48'(ho);
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    cfgAddr = '0;
    cfgWr = 1'b0;
    cfgRd = 1'b0;
    cfgByteEn = 4'h0;
    cfgWdata = '0;
    genEvent = '0;
    fOpc = '0;
    aMask = '0;
    aMatch = '0;
    for (int i = 0; i < 4; i++) begin
      expCnt[i] = '0;
    end
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    // Reset values, writable bits, reserved bits and partial byte writes
    for (int k = 0; k < 5; k++) begin
      rd_chk(FOFF[k], 32'h0000_0000);
      cfg_wr(FOFF[k], FONES[k], 4'hF);
      rd_chk(FOFF[k], FONES[k]);
    end
    cfg_wr(12'h4A0, 32'h0000_0000, 4'h2);
    rd_chk(12'h4A0, 32'h0FFF_00FF);
    rd_chk(12'h4A4, 32'h0000_0000);
    set_filt(32'h0000_0000, '0, '0);
    // Counters 0..2 on the packet-hit event, counter 3 on generic event 1
    for (int i = 0; i < 3; i++) begin
      cfg_wr(12'h420 + 12'(4 * i), 32'h0040_0040, 4'hF);
      rd_chk(12'h420 + 12'(4 * i), 32'h0040_0040);
    end
    cfg_wr(12'h42C, 32'h0040_0001, 4'hF);
    // Cleared masks: both directions hit in the same cycle
    pkt(1'b1, 4'h7, 4'h3, 47'h1234, 1'b1, 6'h11, 47'h5678);
    pkt(1'b1, 4'h1, 4'hE, '1, 1'b0, 6'h00, '0);
    for (int i = 0; i < 3; i++) begin
      ctr_chk(i);
    end
    // Each incoming class code matched exactly, its neighbour refused
    for (int k = 0; k < 5; k++) begin
      set_filt({20'h00000, 4'hF, CODES[k], 8'h00}, '0, '0);
      pkt(1'b1, CODES[k], 4'h6, 47'h0, 1'b0, 6'h00, '0);
      pkt(1'b1, CODES[k] ^ 4'h1, 4'h6, 47'h0, 1'b0, 6'h00, '0);
      ctr_chk(0);
    end
    // Outgoing opcode mask and value, incoming left open
    set_filt({4'h0, 6'h3F, 6'h2A, 16'h0000}, '0, '0);
    pkt(1'b1, 4'h2, 4'h9, 47'h0, 1'b1, 6'h2A, 47'h0);
    pkt(1'b0, 4'h2, 4'h9, 47'h0, 1'b1, 6'h2B, 47'h0);
    pkt(1'b0, 4'h2, 4'h9, 47'h0, 1'b1, 6'h0A, 47'h0);
    ctr_chk(1);
    // Incoming opcode, full mask then a partial mask
    set_filt(32'h0000_00F5, '0, '0);
    pkt(1'b1, 4'hC, 4'h5, 47'h0, 1'b1, 6'h3F, 47'h0);
    pkt(1'b1, 4'hC, 4'h4, 47'h0, 1'b0, 6'h00, 47'h0);
    set_filt(32'h0000_0035, '0, '0);
    pkt(1'b1, 4'hC, 4'h9, 47'h0, 1'b0, 6'h00, 47'h0);
    pkt(1'b1, 4'hC, 4'h6, 47'h0, 1'b0, 6'h00, 47'h0);
    ctr_chk(2);
    // Address top bit and bit 0, shared by both directions
    set_filt(32'h0000_0000, {1'b1, 45'h0, 1'b1}, {1'b1, 14'h0, 31'h0, 1'b1});
    pkt(1'b1, 4'h0, 4'h0, {1'b1, 45'h0, 1'b1}, 1'b1, 6'h00, {1'b1, 45'h1234, 1'b1});
    pkt(1'b1, 4'h0, 4'h0, {1'b0, 45'h0, 1'b1}, 1'b1, 6'h00, {1'b1, 45'h0, 1'b0});
    pkt(1'b1, 4'h0, 4'h0, {1'b1, 45'h7, 1'b0}, 1'b1, 6'h00, {1'b0, 45'h0, 1'b1});
    ctr_chk(0);
    // Clear bit empties counter 0 and is not stored
    cfg_wr(12'h420, 32'h0042_0040, 4'hF);
    expCnt[0] = 48'h0;
    rd_chk(12'h420, 32'h0040_0040);
    ctr_chk(0);
    // Generic events: bit 1 selected, bit 2 not
    for (int n = 0; n < 3; n++) begin
      @(posedge clk);
      #1;
      genEvent = 16'h0006;
      @(posedge clk);
      #1;
      genEvent = 16'h0000;
    end
    expCnt[3] = 48'h3;
    ctr_chk(3);
    // Mid-run reset returns counters and filters to zero
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    expCnt[3] = 48'h0;
    ctr_chk(3);
    rd_chk(12'h494, 32'h0000_0000);
    rd_chk(12'h4A0, 32'h0000_0000);
    close_out();
  end
endmodule
`default_nettype wire
